// ---- verilog/uart_abw_pkg.sv ----
// constants and carrier types for the auto-baud, wake-up and break logic
package uart_abw_pkg;
	// register byte offsets
	localparam logic [4:0] OFS_BAUD_CTRL = 5'h00;
	localparam logic [4:0] OFS_DIV_LOW = 5'h04;
	localparam logic [4:0] OFS_DIV_HIGH = 5'h08;
	localparam logic [4:0] OFS_TX_CTRL = 5'h0c;
	localparam logic [4:0] OFS_RX_STAT = 5'h10;
	localparam logic [4:0] OFS_RX_DATA = 5'h14;
	localparam logic [4:0] OFS_TX_DATA = 5'h18;
	// baud_control_reg fields
	localparam int BIT_ABD_EN = 0;
	localparam int BIT_WAKE_EN = 1;
	localparam int BIT_WIDE = 3;
	localparam int BIT_RX_IDLE = 6;
	localparam int BIT_ABD_OVF = 7;
	// tx_status_control fields
	localparam int BIT_SHIFT_EMPTY = 1;
	localparam int BIT_HIGH_SPEED = 2;
	localparam int BIT_SEND_BREAK = 3;
	localparam int BIT_TX_ON = 5;
	// rx_status_control fields
	localparam int BIT_RX_INT = 0;
	localparam int BIT_TX_INT = 1;
	localparam int BIT_FRAME_ERR = 2;
	// prescaler masks: base clock and auto-baud clock
	localparam logic [8:0] MASK_BASE_00 = 9'h03f;
	localparam logic [8:0] MASK_BASE_01 = 9'h00f;
	localparam logic [8:0] MASK_BASE_11 = 9'h003;
	localparam logic [8:0] MASK_ABD_00 = 9'h1ff;
	localparam logic [8:0] MASK_ABD_01 = 9'h07f;
	localparam logic [8:0] MASK_ABD_11 = 9'h01f;
	// frame shape
	localparam logic [3:0] DATA_LAST = 4'h7;
	localparam logic [3:0] TX_STOP_NORMAL = 4'h9;
	localparam logic [3:0] TX_STOP_BREAK = 4'hd;
	localparam logic [2:0] ABD_LAST_RISE = 3'h4;
	localparam logic [15:0] ABD_COUNT_START = 16'h0001;
	localparam logic [15:0] DIV_RESET = 16'h0000;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	typedef struct packed {
		logic read;
		logic write;
		logic [4:0] address;
		logic [31:0] writedata;
	} avs_req_t;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_BITS = 2'b10,
		RX_STOP = 2'b11
	} rx_state_t;

	typedef enum logic [1:0] {
		AB_IDLE = 2'b00,
		AB_START = 2'b01,
		AB_RISE1 = 2'b10,
		AB_COUNT = 2'b11
	} ab_state_t;
endpackage : uart_abw_pkg

// ---- verilog/uart_autobaud_wakeup_break.sv ----
// auto-baud, wake-up and break logic with its avalon-mm register slave
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - auto-baud times a 55h sync character on the receive line.
// - setting auto-baud enable starts calibration; normal receiver held idle.
// - divisor pair counts auto-baud clocks from the first rise after start.
// - counter starts at one; software may subtract one afterwards.
// - fifth rise keeps the count, clears auto-baud enable, sets receive flag.
// - after auto-baud the receive flag clears by reading receive data.
// - during auto-baud both divisor bytes form one 16-bit counter.
// - wide and high-speed bits select base and auto-baud clock dividers.
// - 8-bit low-speed rate is clock over 64 times divisor plus one.
// - counter overflow sets overflow and receive flag, counting continues.
// - receive idle reads zero during auto-baud, set at fifth rise.
// - receive data read after overflow: fifth rise sets receive flag again.
// - wake enable disables reception and watches for a falling edge.
// - the wake edge sets the receive flag; reading receive data clears it.
// - rising edge ending the break clears wake enable; receiver then idles.
// - wake plus auto-baud measures the character after the break.
// - send-break with transmit on sends start, twelve zeros and stop.
// - send-break clears after the break stop; queued byte follows.
// - shift-empty shows activity during a break like a normal character.
// - received break shows receive flag, framing error and zero data.
// - writing the divisor resets the baud timer immediately.
module uart_autobaud_wakeup_break (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire uart_abw_pkg::avs_req_t avs_req,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic rx_line,
	output logic tx_line
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////
	// register bus: one wait cycle, access acts when waitrequest is low
	logic wait_r, wait_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic acc, wr_acc, rd_acc;
	logic [31:0] read_mux;

	assign acc = (avs_req.read | avs_req.write) & ~wait_r;
	assign wr_acc = acc & avs_req.write;
	assign rd_acc = acc & avs_req.read;

	always_comb
	begin
		wait_nxt = 1'b1;
		rdata_nxt = rdata_r;
		if ((avs_req.read | avs_req.write) & wait_r)
		begin
			wait_nxt = 1'b0;
			rdata_nxt = read_mux;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wait_r <= 1'b1;
			rdata_r <= 32'h0000_0000;
		end
		else
		begin
			wait_r <= wait_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign avs_waitrequest = wait_r;
	assign avs_readdata = rdata_r;

	////////////////////////////////////////////////////////////////////////
	// control state, shared by the clock, receive and transmit groups
	logic auto_baud_enable_r, wue_r, wide_r, ovf_r, hs_r, send_break_request_r, txon_r;
	logic [15:0] div_r;
	logic rif_r, framing_error_flag_r;
	logic [7:0] rxd_r;
	logic rx_prev_r;
	logic fall, rise, rx_idle;
	logic div_wr, brk_done;

	assign fall = rx_prev_r & ~rx_line;
	assign rise = ~rx_prev_r & rx_line;
	assign div_wr = wr_acc & ((avs_req.address == uart_abw_pkg::OFS_DIV_LOW) |
		(avs_req.address == uart_abw_pkg::OFS_DIV_HIGH));

	////////////////////////////////////////////////////////////////////////
	// prescaler and baud timer
	logic [8:0] pre_r, pre_nxt;
	logic [15:0] bt_r, bt_nxt;
	logic [8:0] base_mask, abd_mask;
	logic base_en, abd_en, baud_tick;
	logic [15:0] div_top;

	always_comb
	begin
		case ({wide_r, hs_r})
			2'b00:
			begin
				base_mask = uart_abw_pkg::MASK_BASE_00;
				abd_mask = uart_abw_pkg::MASK_ABD_00;
			end
			2'b11:
			begin
				base_mask = uart_abw_pkg::MASK_BASE_11;
				abd_mask = uart_abw_pkg::MASK_ABD_11;
			end
			default:
			begin
				base_mask = uart_abw_pkg::MASK_BASE_01;
				abd_mask = uart_abw_pkg::MASK_ABD_01;
			end
		endcase
	end

	assign base_en = (pre_r & base_mask) == base_mask;
	assign abd_en = (pre_r & abd_mask) == abd_mask;
	// narrow mode uses the low byte only: rate = base / (n + 1)
	assign div_top = wide_r ? div_r : {8'h00, div_r[7:0]};
	assign baud_tick = base_en & (bt_r == div_top);

	always_comb
	begin
		pre_nxt = pre_r + 9'h001;
		bt_nxt = bt_r;
		if (base_en)
			bt_nxt = baud_tick ? 16'h0000 : bt_r + 16'h0001;
		if (div_wr)
		begin
			pre_nxt = 9'h000;
			bt_nxt = 16'h0000;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pre_r <= 9'h000;
			bt_r <= 16'h0000;
		end
		else
		begin
			pre_r <= pre_nxt;
			bt_r <= bt_nxt;
		end
	end

	a_div_wr_reset: assert property (div_wr |=> bt_r == 16'h0000)
		else $error("baud timer not reset by divisor write");

	////////////////////////////////////////////////////////////////////////
	// receiver, auto-baud, wake-up and software registers
	uart_abw_pkg::rx_state_t rx_st_r, rx_st_nxt;
	uart_abw_pkg::ab_state_t ab_st_r, ab_st_nxt;
	logic [15:0] rc_r, rc_nxt, div_nxt;
	logic [3:0] ri_r, ri_nxt;
	logic [7:0] rsh_r, rsh_nxt, rxd_nxt;
	logic [2:0] edges_r, edges_nxt;
	logic woke_r, woke_nxt;
	logic auto_baud_enable_nxt, wue_nxt, wide_nxt, ovf_nxt, hs_nxt, send_break_request_nxt, txon_nxt;
	logic rif_nxt, framing_error_flag_nxt, rif_set;

	// idle only when neither measuring nor receiving
	assign rx_idle = (rx_st_r == uart_abw_pkg::RX_IDLE) & ~auto_baud_enable_r &
		(ab_st_r == uart_abw_pkg::AB_IDLE);

	always_comb
	begin
		rx_st_nxt = rx_st_r;
		ab_st_nxt = ab_st_r;
		rc_nxt = rc_r;
		ri_nxt = ri_r;
		rsh_nxt = rsh_r;
		rxd_nxt = rxd_r;
		edges_nxt = edges_r;
		woke_nxt = woke_r;
		div_nxt = div_r;
		auto_baud_enable_nxt = auto_baud_enable_r;
		wue_nxt = wue_r;
		wide_nxt = wide_r;
		ovf_nxt = ovf_r;
		hs_nxt = hs_r;
		send_break_request_nxt = send_break_request_r & ~brk_done;
		txon_nxt = txon_r;
		framing_error_flag_nxt = framing_error_flag_r;
		rif_set = 1'b0;
		// software writes first, hardware events below win over them
		if (wr_acc)
		begin
			case (avs_req.address)
				uart_abw_pkg::OFS_BAUD_CTRL:
				begin
					auto_baud_enable_nxt = avs_req.writedata[uart_abw_pkg::BIT_ABD_EN];
					wue_nxt = avs_req.writedata[uart_abw_pkg::BIT_WAKE_EN];
					wide_nxt = avs_req.writedata[uart_abw_pkg::BIT_WIDE];
					ovf_nxt = avs_req.writedata[uart_abw_pkg::BIT_ABD_OVF];
				end
				uart_abw_pkg::OFS_DIV_LOW: div_nxt[7:0] = avs_req.writedata[7:0];
				uart_abw_pkg::OFS_DIV_HIGH: div_nxt[15:8] = avs_req.writedata[7:0];
				uart_abw_pkg::OFS_TX_CTRL:
				begin
					hs_nxt = avs_req.writedata[uart_abw_pkg::BIT_HIGH_SPEED];
					send_break_request_nxt = avs_req.writedata[uart_abw_pkg::BIT_SEND_BREAK];
					txon_nxt = avs_req.writedata[uart_abw_pkg::BIT_TX_ON];
				end
				default: ;
			endcase
		end
		// wake-up watch, receiver stays idle meanwhile
		if (wue_r)
		begin
			rx_st_nxt = uart_abw_pkg::RX_IDLE;
			// wake edge raises the receive flag
			if (fall)
			begin
				rif_set = 1'b1;
				woke_nxt = 1'b1;
			end
			// end of break clears wake enable
			if (rise & woke_r)
			begin
				wue_nxt = 1'b0;
				woke_nxt = 1'b0;
			end
		end
		else
			woke_nxt = 1'b0;
		// measurement runs once wake-up is finished
		case (ab_st_r)
			uart_abw_pkg::AB_IDLE:
				if (auto_baud_enable_r & ~wue_r)
					ab_st_nxt = uart_abw_pkg::AB_START;
			uart_abw_pkg::AB_START:
				if (fall)
					ab_st_nxt = uart_abw_pkg::AB_RISE1;
			uart_abw_pkg::AB_RISE1:
				if (rise)
				begin
					// count starts at one on the first rise
					ab_st_nxt = uart_abw_pkg::AB_COUNT;
					div_nxt = uart_abw_pkg::ABD_COUNT_START;
					edges_nxt = 3'h1;
				end
			uart_abw_pkg::AB_COUNT:
				if (rise & (edges_r == uart_abw_pkg::ABD_LAST_RISE))
				begin
					ab_st_nxt = uart_abw_pkg::AB_IDLE;
					auto_baud_enable_nxt = 1'b0;
					rif_set = 1'b1;
				end
				else
				begin
					if (rise)
						edges_nxt = edges_r + 3'h1;
					if (abd_en)
					begin
						div_nxt = div_r + 16'h0001;
						if (div_r == 16'hffff)
						begin
							ovf_nxt = 1'b1;
							rif_set = 1'b1;
						end
					end
				end
			default: ab_st_nxt = uart_abw_pkg::AB_IDLE;
		endcase
		if (~auto_baud_enable_r)
			ab_st_nxt = uart_abw_pkg::AB_IDLE;
		// normal receiver only without auto-baud or wake
		if (~auto_baud_enable_r & ~wue_r & (ab_st_r == uart_abw_pkg::AB_IDLE))
		begin
			case (rx_st_r)
				uart_abw_pkg::RX_IDLE:
					if (fall)
					begin
						rx_st_nxt = uart_abw_pkg::RX_START;
						rc_nxt = 16'h0000;
					end
				uart_abw_pkg::RX_START:
					if (base_en)
					begin
						if (rc_r == {1'b0, div_top[15:1]})
						begin
							rx_st_nxt = rx_line ? uart_abw_pkg::RX_IDLE : uart_abw_pkg::RX_BITS;
							rc_nxt = 16'h0000;
							ri_nxt = 4'h0;
						end
						else
							rc_nxt = rc_r + 16'h0001;
					end
				uart_abw_pkg::RX_BITS:
					if (base_en)
					begin
						if (rc_r == div_top)
						begin
							rc_nxt = 16'h0000;
							rsh_nxt = {rx_line, rsh_r[7:1]};
							ri_nxt = ri_r + 4'h1;
							if (ri_r == uart_abw_pkg::DATA_LAST)
								rx_st_nxt = uart_abw_pkg::RX_STOP;
						end
						else
							rc_nxt = rc_r + 16'h0001;
					end
				uart_abw_pkg::RX_STOP:
					if (base_en)
					begin
						if (rc_r == div_top)
						begin
							// a break lands as zero data with framing error
							rx_st_nxt = uart_abw_pkg::RX_IDLE;
							rxd_nxt = rsh_r;
							framing_error_flag_nxt = ~rx_line;
							rif_set = 1'b1;
						end
						else
							rc_nxt = rc_r + 16'h0001;
					end
				default: rx_st_nxt = uart_abw_pkg::RX_IDLE;
			endcase
		end
		// read of receive data clears the flag, a new event wins
		rif_nxt = rif_set | (rif_r & ~(rd_acc & (avs_req.address == uart_abw_pkg::OFS_RX_DATA)));
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_st_r <= uart_abw_pkg::RX_IDLE;
			ab_st_r <= uart_abw_pkg::AB_IDLE;
			rc_r <= 16'h0000;
			ri_r <= 4'h0;
			rsh_r <= uart_abw_pkg::CTRL_RESET;
			rxd_r <= uart_abw_pkg::CTRL_RESET;
			edges_r <= 3'h0;
			woke_r <= 1'b0;
			div_r <= uart_abw_pkg::DIV_RESET;
			{auto_baud_enable_r, wue_r, wide_r, ovf_r, hs_r, send_break_request_r, txon_r} <= 7'h00;
			rif_r <= 1'b0;
			framing_error_flag_r <= 1'b0;
			rx_prev_r <= 1'b1;
		end
		else
		begin
			rx_st_r <= rx_st_nxt;
			ab_st_r <= ab_st_nxt;
			rc_r <= rc_nxt;
			ri_r <= ri_nxt;
			rsh_r <= rsh_nxt;
			rxd_r <= rxd_nxt;
			edges_r <= edges_nxt;
			woke_r <= woke_nxt;
			div_r <= div_nxt;
			{auto_baud_enable_r, wue_r, wide_r, ovf_r} <= {auto_baud_enable_nxt, wue_nxt, wide_nxt, ovf_nxt};
			{hs_r, send_break_request_r, txon_r} <= {hs_nxt, send_break_request_nxt, txon_nxt};
			rif_r <= rif_nxt;
			framing_error_flag_r <= framing_error_flag_nxt;
			rx_prev_r <= rx_line;
		end
	end

	sequence s_first_rise;
		(ab_st_r == uart_abw_pkg::AB_RISE1) && rise;
	endsequence
	sequence s_fifth_rise;
		(ab_st_r == uart_abw_pkg::AB_COUNT) && rise && (edges_r == uart_abw_pkg::ABD_LAST_RISE);
	endsequence

	a_abd_holds_rx: assert property (auto_baud_enable_r |-> rx_st_r == uart_abw_pkg::RX_IDLE)
		else $error("receiver left idle during auto-baud");
	a_count_from_one: assert property (s_first_rise |=> div_r == 16'h0001 && !rx_idle)
		else $error("auto-baud count did not start at one");
	a_fifth_rise_done: assert property (s_fifth_rise |=> !auto_baud_enable_r && rif_r && rx_idle
		&& div_r == $past(div_r))
		else $error("fifth rise did not finish auto-baud");
	a_overflow_flag: assert property ((ab_st_r == uart_abw_pkg::AB_COUNT) && abd_en && !rise
		&& div_r == 16'hffff |=> ovf_r && rif_r && div_r == 16'h0000)
		else $error("overflow not flagged");
	a_idle_low_abd: assert property (ab_st_r != uart_abw_pkg::AB_IDLE |-> !rx_idle)
		else $error("receive idle set during auto-baud");
	a_wake_sets_flag: assert property (wue_r && fall |=> rif_r && woke_r)
		else $error("wake edge missed");
	a_wake_clears_en: assert property (wue_r && woke_r && rise && !wr_acc |=> !wue_r)
		else $error("wake enable not cleared at break end");

	////////////////////////////////////////////////////////////////////////
	// transmitter: one-byte holding buffer and shifter
	logic buf_full_r, buf_full_nxt, busy_r, busy_nxt, brk_r, brk_nxt, tx_r, tx_nxt;
	logic [7:0] buf_r, buf_nxt, tsh_r, tsh_nxt;
	logic [3:0] ti_r, ti_nxt, t_last;
	logic tx_load, tdata_wr;

	assign tdata_wr = wr_acc & (avs_req.address == uart_abw_pkg::OFS_TX_DATA);
	assign tx_load = baud_tick & ~busy_r & buf_full_r & txon_r;
	assign t_last = brk_r ? uart_abw_pkg::TX_STOP_BREAK : uart_abw_pkg::TX_STOP_NORMAL;
	assign brk_done = baud_tick & busy_r & brk_r & (ti_r == t_last);

	always_comb
	begin
		buf_full_nxt = buf_full_r;
		buf_nxt = buf_r;
		busy_nxt = busy_r;
		brk_nxt = brk_r;
		tx_nxt = tx_r;
		tsh_nxt = tsh_r;
		ti_nxt = ti_r;
		if (tx_load)
		begin
			// break frame chosen at load, written value ignored
			buf_full_nxt = 1'b0;
			busy_nxt = 1'b1;
			brk_nxt = send_break_request_r;
			tsh_nxt = send_break_request_r ? 8'h00 : buf_r;
			tx_nxt = 1'b0;
			ti_nxt = 4'h0;
		end
		else if (baud_tick & busy_r)
		begin
			if (ti_r == t_last)
			begin
				busy_nxt = 1'b0;
				brk_nxt = 1'b0;
			end
			else
			begin
				ti_nxt = ti_r + 4'h1;
				tx_nxt = (ti_r + 4'h1 == t_last) ? 1'b1 : tsh_r[0];
				tsh_nxt = {1'b0, tsh_r[7:1]};
			end
		end
		if (tdata_wr)
		begin
			buf_full_nxt = 1'b1;
			buf_nxt = avs_req.writedata[7:0];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{buf_full_r, busy_r, brk_r} <= 3'h0;
			tx_r <= 1'b1;
			buf_r <= 8'h00;
			tsh_r <= 8'h00;
			ti_r <= 4'h0;
		end
		else
		begin
			{buf_full_r, busy_r, brk_r} <= {buf_full_nxt, busy_nxt, brk_nxt};
			tx_r <= tx_nxt;
			buf_r <= buf_nxt;
			tsh_r <= tsh_nxt;
			ti_r <= ti_nxt;
		end
	end

	assign tx_line = tx_r;

	a_break_low: assert property (busy_r && brk_r && ti_r != t_last |-> !tx_r)
		else $error("break frame bit not low");
	a_send_break_request_clear: assert property (brk_done && !wr_acc |=> !send_break_request_r && !busy_r)
		else $error("send-break not cleared after break");

	////////////////////////////////////////////////////////////////////////
	// read multiplexer
	always_comb
	begin
		read_mux = 32'h0000_0000;
		case (avs_req.address)
			uart_abw_pkg::OFS_BAUD_CTRL:
			begin
				read_mux[uart_abw_pkg::BIT_ABD_EN] = auto_baud_enable_r;
				read_mux[uart_abw_pkg::BIT_WAKE_EN] = wue_r;
				read_mux[uart_abw_pkg::BIT_WIDE] = wide_r;
				read_mux[uart_abw_pkg::BIT_RX_IDLE] = rx_idle;
				read_mux[uart_abw_pkg::BIT_ABD_OVF] = ovf_r;
			end
			uart_abw_pkg::OFS_DIV_LOW: read_mux[7:0] = div_r[7:0];
			uart_abw_pkg::OFS_DIV_HIGH: read_mux[7:0] = div_r[15:8];
			uart_abw_pkg::OFS_TX_CTRL:
			begin
				// shift-empty follows the shifter for every frame
				read_mux[uart_abw_pkg::BIT_SHIFT_EMPTY] = ~busy_r;
				read_mux[uart_abw_pkg::BIT_HIGH_SPEED] = hs_r;
				read_mux[uart_abw_pkg::BIT_SEND_BREAK] = send_break_request_r;
				read_mux[uart_abw_pkg::BIT_TX_ON] = txon_r;
			end
			uart_abw_pkg::OFS_RX_STAT:
			begin
				read_mux[uart_abw_pkg::BIT_RX_INT] = rif_r;
				read_mux[uart_abw_pkg::BIT_TX_INT] = ~buf_full_r;
				read_mux[uart_abw_pkg::BIT_FRAME_ERR] = framing_error_flag_r;
			end
			uart_abw_pkg::OFS_RX_DATA: read_mux[7:0] = rxd_r;
			default: ;
		endcase
	end
endmodule : uart_autobaud_wakeup_break

`default_nettype wire

// ---- dv/serial_node.sv ----
// remote serial node: drives the receive line and samples the transmit line
`timescale 1ns/100ps
`default_nettype none

module serial_node (
	input wire logic ref_clk,
	input wire logic tx_line,
	output logic rx_line
);
	// the line idles at the mark level
	initial rx_line = 1'b1;

	////////////////////////////////////////////////////////////////////////////
	// one bit held for cyc clocks
	task automatic put_bit(input logic b, input int cyc);
		@(posedge ref_clk);
		rx_line <= b;
		repeat (cyc - 1) @(posedge ref_clk);
	endtask : put_bit

	// 8N1 frame, lsb first
	task automatic send_frame(input logic [7:0] d, input int cyc);
		put_bit(1'b0, cyc);
		for (int i = 0; i < 8; i++)
			put_bit(d[i], cyc);
		put_bit(1'b1, cyc);
	endtask : send_frame

	task automatic send_low(input int nbits, input int cyc);
		repeat (nbits) put_bit(1'b0, cyc);
		put_bit(1'b1, cyc);
	endtask : send_low

	////////////////////////////////////////////////////////////////////////////
	// samples 14 bit centres after a falling edge and counts low cycles
	task automatic grab(input int cyc, output logic [13:0] s, output int low);
		int n;
		n = 0;
		low = 0;
		s = '1;
		while (tx_line !== 1'b0 && n < 40000)
		begin
			@(posedge ref_clk);
			n++;
		end
		for (int i = 0; i < 14 * cyc; i++)
		begin
			if (tx_line === 1'b0)
				low++;
			if (i % cyc == cyc / 2)
				s[i / cyc] = tx_line;
			@(posedge ref_clk);
		end
	endtask : grab
endmodule : serial_node

`default_nettype wire

// ---- dv/uart_autobaud_wakeup_break_tb.sv ----
// self-checking bench for the auto-baud, wake-up and break logic
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) miss(nm, e, g); end

module uart_autobaud_wakeup_break_tb;
	logic ref_clk;
	logic rst_n;
	uart_abw_pkg::avs_req_t avs_req;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic rx_line;
	logic tx_line;
	int errors;
	int total_checks;
	logic [31:0] q;
	logic [15:0] v;
	logic [13:0] s1;
	logic [13:0] s2;
	int lo1;
	int lo2;
	logic [7:0] tbl [4][4];

	uart_autobaud_wakeup_break DUT (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.avs_req(avs_req),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.rx_line(rx_line),
		.tx_line(tx_line)
	);

	serial_node node (
		.ref_clk(ref_clk),
		.tx_line(tx_line),
		.rx_line(rx_line)
	);

	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic miss(input string nm, input logic [31:0] e, input logic [31:0] g);
		errors++;
		$display("MISMATCH %s expected %0h seen %0h", nm, e, g);
	endtask : miss

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish

	// one avalon access, held until waitrequest is seen low
	task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_req.read <= !w;
		avs_req.write <= w;
		avs_req.address <= a;
		avs_req.writedata <= {24'h0, d};
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		avs_req <= '0;
		if (n >= 50)
		begin
			miss("bus answer", 32'h0, 32'h1);
			tally_and_finish();
		end
	endtask : xfer

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task automatic rchk(input string nm, input logic [4:0] a, input logic [7:0] m,
		input logic [7:0] e);
		xfer(1'b0, a, 8'h00);
		`CHK(nm, e, q[7:0] & m)
	endtask : rchk

	task automatic poll(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
		int n;
		n = 0;
		do
		begin
			xfer(1'b0, a, 8'h00);
			n++;
		end
		while ((q[7:0] & m) !== e && n < 3000);
		if (n >= 3000)
		begin
			miss("poll", e, q);
			tally_and_finish();
		end
	endtask : poll

	// divisor pair within one count of the expected measurement
	task automatic divchk(input int e);
		xfer(1'b0, uart_abw_pkg::OFS_DIV_LOW, 8'h00);
		v[7:0] = q[7:0];
		xfer(1'b0, uart_abw_pkg::OFS_DIV_HIGH, 8'h00);
		v[15:8] = q[7:0];
		`CHK("divisor in range", 1'b1, (v >= e - 1 && v <= e + 1))
	endtask : divchk

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		rst_n = 1'b0;
		avs_req = '0;
		errors = 0;
		total_checks = 0;
		// each row gives a 64-clock bit: ctrl, tx ctrl, divisor low, high
		tbl = '{'{8'h08, 8'h24, 8'h0f, 8'h00}, '{8'h00, 8'h24, 8'h03, 8'h01},
			'{8'h08, 8'h20, 8'h03, 8'h00}, '{8'h00, 8'h20, 8'h00, 8'h01}};
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;

		rchk("ctrl reset", uart_abw_pkg::OFS_BAUD_CTRL, 8'hff, 8'h40);
		rchk("tx ctrl reset", uart_abw_pkg::OFS_TX_CTRL, 8'hff, 8'h02);
		rchk("div low reset", uart_abw_pkg::OFS_DIV_LOW, 8'hff, 8'h00);
		rchk("unmapped", 5'h1c, 8'hff, 8'h00);
		$display("test reset done");

		for (int i = 0; i < 4; i++)
		begin
			wr(uart_abw_pkg::OFS_BAUD_CTRL, tbl[i][0]);
			wr(uart_abw_pkg::OFS_TX_CTRL, tbl[i][1]);
			wr(uart_abw_pkg::OFS_DIV_LOW, tbl[i][2]);
			wr(uart_abw_pkg::OFS_DIV_HIGH, tbl[i][3]);
			wr(uart_abw_pkg::OFS_TX_DATA, 8'hc3);
			node.grab(64, s1, lo1);
			`CHK("tx frame", {1'b1, 8'hc3, 1'b0}, s1[9:0])
			`CHK("tx low time", 5 * 64, lo1)
		end
		$display("test rates done");

		wr(uart_abw_pkg::OFS_BAUD_CTRL, 8'h08);
		wr(uart_abw_pkg::OFS_TX_CTRL, 8'h2c);
		wr(uart_abw_pkg::OFS_DIV_LOW, 8'h0f);
		wr(uart_abw_pkg::OFS_DIV_HIGH, 8'h00);
		fork
			begin
				node.grab(64, s1, lo1);
				node.grab(64, s2, lo2);
			end
			begin
				wr(uart_abw_pkg::OFS_TX_DATA, 8'hff);
				poll(uart_abw_pkg::OFS_TX_CTRL, 8'h02, 8'h00);
				rchk("break held", uart_abw_pkg::OFS_TX_CTRL, 8'h08, 8'h08);
				wr(uart_abw_pkg::OFS_TX_DATA, 8'h55);
			end
		join
		`CHK("break frame", 14'h2000, s1)
		`CHK("break low time", 13 * 64, lo1)
		`CHK("sync after break", {1'b1, 8'h55, 1'b0}, s2[9:0])
		`CHK("sync low time", 5 * 64, lo2)
		rchk("break cleared", uart_abw_pkg::OFS_TX_CTRL, 8'h0a, 8'h02);
		$display("test send break done");

		node.send_frame(8'ha5, 64);
		rchk("rx flags", uart_abw_pkg::OFS_RX_STAT, 8'h05, 8'h01);
		rchk("rx data", uart_abw_pkg::OFS_RX_DATA, 8'hff, 8'ha5);
		rchk("rx flag read", uart_abw_pkg::OFS_RX_STAT, 8'h01, 8'h00);
		node.send_low(13, 64);
		rchk("break flags", uart_abw_pkg::OFS_RX_STAT, 8'h05, 8'h05);
		rchk("break data", uart_abw_pkg::OFS_RX_DATA, 8'hff, 8'h00);
		$display("test receive done");

		// narrow divisor mode, yet the count passes 255
		wr(uart_abw_pkg::OFS_BAUD_CTRL, 8'h01);
		wr(uart_abw_pkg::OFS_TX_CTRL, 8'h24);
		rchk("measure start", uart_abw_pkg::OFS_BAUD_CTRL, 8'h41, 8'h01);
		fork
			node.send_frame(8'h55, 4352);
			begin
				repeat (20000) @(posedge ref_clk);
				rchk("measure busy", uart_abw_pkg::OFS_BAUD_CTRL, 8'h41, 8'h01);
			end
		join
		rchk("measure end", uart_abw_pkg::OFS_BAUD_CTRL, 8'hc1, 8'h40);
		rchk("measure flag", uart_abw_pkg::OFS_RX_STAT, 8'h01, 8'h01);
		divchk(273);
		// measuring leaves the last received byte, the break's zero, in place
		rchk("measure read", uart_abw_pkg::OFS_RX_DATA, 8'hff, 8'h00);
		rchk("measure flag read", uart_abw_pkg::OFS_RX_STAT, 8'h01, 8'h00);
		$display("test auto baud done");

		wr(uart_abw_pkg::OFS_BAUD_CTRL, 8'h0b);
		fork
			node.send_low(13, 64);
			begin
				repeat (100) @(posedge ref_clk);
				rchk("wake flag", uart_abw_pkg::OFS_RX_STAT, 8'h01, 8'h01);
				rchk("wake held", uart_abw_pkg::OFS_BAUD_CTRL, 8'h03, 8'h03);
				rchk("wake read", uart_abw_pkg::OFS_RX_DATA, 8'hff, 8'h00);
			end
		join
		rchk("no frame in wake", uart_abw_pkg::OFS_RX_STAT, 8'h01, 8'h00);
		rchk("wake cleared", uart_abw_pkg::OFS_BAUD_CTRL, 8'h03, 8'h01);
		node.send_frame(8'h55, 32);
		rchk("measure after wake", uart_abw_pkg::OFS_BAUD_CTRL, 8'hc1, 8'h40);
		divchk(9);
		$display("test wake done");

		// overflow: the live counter is preset near its top, twice so that
		// one write surely misses a counter tick
		xfer(1'b0, uart_abw_pkg::OFS_RX_DATA, 8'h00);
		wr(uart_abw_pkg::OFS_BAUD_CTRL, 8'h09);
		fork
			node.send_frame(8'h55, 2048);
			begin
				repeat (3000) @(posedge ref_clk);
				wr(uart_abw_pkg::OFS_DIV_HIGH, 8'hff);
				wr(uart_abw_pkg::OFS_DIV_HIGH, 8'hff);
				repeat (10000) @(posedge ref_clk);
				rchk("overflow set", uart_abw_pkg::OFS_BAUD_CTRL, 8'hc1, 8'h81);
				rchk("overflow flag", uart_abw_pkg::OFS_RX_STAT, 8'h01, 8'h01);
				xfer(1'b0, uart_abw_pkg::OFS_RX_DATA, 8'h00);
				rchk("overflow flag read", uart_abw_pkg::OFS_RX_STAT, 8'h01, 8'h00);
				poll(uart_abw_pkg::OFS_BAUD_CTRL, 8'h40, 8'h40);
				rchk("flag at fifth rise", uart_abw_pkg::OFS_RX_STAT, 8'h01, 8'h01);
				xfer(1'b0, uart_abw_pkg::OFS_RX_DATA, 8'h00);
				wr(uart_abw_pkg::OFS_BAUD_CTRL, 8'h08);
			end
		join
		rchk("overflow cleared", uart_abw_pkg::OFS_BAUD_CTRL, 8'hc1, 8'h40);
		$display("test overflow done");
		tally_and_finish();
	end
endmodule : uart_autobaud_wakeup_break_tb

`default_nettype wire
